// ==== scv_consts.vh ====
// Purpose: Named constants for the serial configuration register block
// Assumes: 16-bit registers behind an 8-bit address, 100 MHz MCLK
// Notes:   Definitions only; included by the register block
`ifndef SCV_CONSTS_VH
`define SCV_CONSTS_VH

// Register addresses
`define SCV_ADDR_SOFT_RESET   8'h00
`define SCV_ADDR_ATT_RESET    8'h03
`define SCV_ADDR_LVDS_CURRENT 8'h11
`define SCV_ADDR_NOISE        8'h14
`define SCV_ADDR_ATT_LOW      8'h16
`define SCV_ADDR_ATT_MID      8'h17
`define SCV_ADDR_ATT_HIGH     8'h18
`define SCV_ADDR_GAIN_A       8'h2A
`define SCV_ADDR_GAIN_B       8'h2B
`define SCV_ADDR_CLOCKING     8'h42
`define SCV_ADDR_FORMAT       8'h46

// Field positions
`define SCV_BIT_SOFT_RESET    0
`define SCV_BIT_ATT_RESET     5
`define SCV_BIT_NOISE         0
`define SCV_BIT_DIFF_CLK      0
`define SCV_BIT_DCC           2
`define SCV_BIT_EXT_REF       3
`define SCV_PHASE_LO          5
`define SCV_BIT_TWOS          2
`define SCV_BIT_MSB_FIRST     3
`define SCV_BIT_SDR           4
`define SCV_CUR_CLK_LO        0
`define SCV_CUR_DATA_LO       3

// Reset values
`define SCV_ATT_LOW_RESET     16'h0020
`define SCV_ATT_MID_RESET     16'h0000
`define SCV_ATT_HIGH_RESET    8'h00
`define SCV_ZERO16            16'h0000
`define SCV_ATT_FORCED_ONES   40'h00_0000_0003

// Frame layout
`define SCV_ADDR_BITS         8
`define SCV_DATA_BITS         16
`define SCV_ATT_BITS          40
`define SCV_ATT_LAST_BIT      6'h27

// Timing
`define SCV_MCLK_KHZ          100000
`define SCV_OSC_KHZ           6000

`endif

// ==== scv_serial_config.v ====
// Purpose: Serial configuration registers with attenuator word forwarding
// Assumes: Host frames writes with SEN_N low, 8-bit address then 16-bit
//          words, MSB first, sampled on SCLK rising edge
// Notes:   Rules carried out are listed below
// Functional notes
// - Writing 1 to reset register bit 0 resets all registers; bit self-clears.
// - Attenuator word spans three registers: bits 0-15, 16-31, 32-39.
// - Word bits 0 and 1 always shift out as ones.
// - Attenuator clock and data idle unless attenuator registers written.
// - Every forwarding sends the whole 40-bit word.
// - Forward only when a write changed stored contents.
// - Untouched registers contribute current or default contents.
// - Three attenuator registers may be written in one framed write.
// - Attenuator clock about 6 MHz, running only during the 40 bits.
// - Register 42 bit selects external reference via common-mode pin.
// - Register 42 bit enables duty-cycle correction, default off.
// - Register 42 bit selects differential clock, default single-ended.
// - Register 14 enables low-frequency noise suppression, default off.
// - Registers 2A and 2B hold per-channel digital gain, default 0 dB.
// - Register 46 bit selects two's complement, default offset binary.
// - Register 46 bit selects MSB first, default LSB first.
// - Register 46 bit selects single data rate, default double.
// - Register 42 field sets output bit clock phase.
// - Register 11 sets clock and data LVDS current, default 3.5 mA.
// - Attenuator reset bit holds forwarding machine reset until cleared.
// - Attenuator chip select high on hardware reset or attenuator reset.
// - Attenuator reset restores word defaults and keeps outputs quiet.
`timescale 1ns/1ns
`default_nettype none
`include "scv_consts.vh"

module scv_serial_config #(
	parameter MCLK_KHZ = `SCV_MCLK_KHZ,
	parameter OSC_KHZ  = `SCV_OSC_KHZ
) (
	input  wire        MCLK,
	input  wire        RESETN,
	input  wire        SEN_N,
	input  wire        SCLK,
	input  wire        SDATA,
	output reg         ATTENUATOR_SERIAL_CLOCK,
	output reg         ATTENUATOR_SERIAL_DATA,
	output reg         ATTENUATOR_CHIP_SELECT,
	output reg         ATTENUATOR_BUSY,
	output reg         EXT_REF_COMMON_MODE,
	output reg         DCC_ENABLE,
	output reg         DIFF_CLOCK,
	output reg         NOISE_SUPPRESS,
	output reg  [31:0] DIGITAL_GAIN,
	output reg         TWOS_COMPLEMENT_FORMAT,
	output reg         MSB_FIRST,
	output reg         SDR_MODE,
	output reg  [1:0]  OUTPUT_BIT_CLOCK_PHASE,
	output reg  [2:0]  LVDS_CLOCK_CURRENT,
	output reg  [2:0]  LVDS_DATA_CURRENT
);

	// Half period of the gated oscillator, rounded down, at least one cycle
	localparam integer HALF_RAW = MCLK_KHZ / (2 * OSC_KHZ);
	localparam [7:0] HALF_CYCLES = (HALF_RAW < 1) ? 8'h01 : HALF_RAW[7:0];

	localparam ST_IDLE  = 1'b0;
	localparam ST_SHIFT = 1'b1;

	// Write targets one of the three attenuator word registers
	function is_att;
		input [7:0] a;
		begin
			is_att = (a == `SCV_ADDR_ATT_LOW) || (a == `SCV_ADDR_ATT_MID) ||
				(a == `SCV_ADDR_ATT_HIGH);
		end
	endfunction

	// Pin synchronisers; stage one feeds stage two only
	reg  [2:0]  sen_sync;
	reg  [2:0]  sclk_sync;
	reg  [1:0]  sdata_sync;
	wire        sclk_rise = sclk_sync[1] & ~sclk_sync[2];
	wire        frame_on  = ~sen_sync[1];
	wire        frame_end = sen_sync[1] & ~sen_sync[2];

	reg  [7:0]  addr;
	reg  [15:0] shift_in;
	reg  [4:0]  bit_cnt;
	reg         addr_done;
	reg         wr_stb;
	reg  [7:0]  wr_addr;
	reg  [15:0] wr_data;
	reg         soft_rst;
	reg         att_rst;
	reg  [15:0] att_low;
	reg  [15:0] att_mid;
	reg  [7:0]  att_high;
	reg         changed;
	reg         pending;
	reg         state;
	reg  [7:0]  div_cnt;
	reg  [5:0]  out_cnt;
	reg  [39:0] out_word;

	wire        clr_all = ~RESETN | soft_rst;
	wire [39:0] att_word = {att_high, att_mid, att_low} |
		`SCV_ATT_FORCED_ONES;
	wire        att_hit  = wr_stb & is_att(wr_addr);
	wire        att_diff = (wr_addr == `SCV_ADDR_ATT_LOW  &&
			wr_data != att_low) ||
		(wr_addr == `SCV_ADDR_ATT_MID  && wr_data != att_mid) ||
		(wr_addr == `SCV_ADDR_ATT_HIGH && wr_data[7:0] != att_high);
	wire        change_now = att_hit & att_diff;
	wire        start = (state == ST_IDLE) & pending & ~att_rst;

	// Sample host pins into the MCLK domain
	always @(posedge MCLK) begin
		if (!RESETN) begin
			sen_sync   <= 3'h7;
			sclk_sync  <= 3'h0;
			sdata_sync <= 2'h0;
		end else begin
			sen_sync   <= {sen_sync[1:0], SEN_N};
			sclk_sync  <= {sclk_sync[1:0], SCLK};
			sdata_sync <= {sdata_sync[0], SDATA};
		end
	end

	// Frame deserialiser; words after the address go to rising addresses
	always @(posedge MCLK) begin
		if (!RESETN || !frame_on) begin
			addr      <= 8'h00;
			shift_in  <= 16'h0000;
			bit_cnt   <= 5'h00;
			addr_done <= 1'b0;
			wr_stb    <= 1'b0;
			wr_addr   <= 8'h00;
			wr_data   <= 16'h0000;
		end else begin
			wr_stb <= 1'b0;
			if (sclk_rise) begin
				shift_in <= {shift_in[14:0], sdata_sync[1]};
				if (!addr_done && bit_cnt == `SCV_ADDR_BITS - 1) begin
					addr      <= {shift_in[6:0], sdata_sync[1]};
					addr_done <= 1'b1;
					bit_cnt   <= 5'h00;
				end else if (addr_done &&
						bit_cnt == `SCV_DATA_BITS - 1) begin
					wr_stb  <= 1'b1;
					wr_addr <= addr;
					wr_data <= {shift_in[14:0], sdata_sync[1]};
					addr    <= addr + 8'h01;
					bit_cnt <= 5'h00;
				end else begin
					bit_cnt <= bit_cnt + 5'h01;
				end
			end
		end
	end

	// Configuration registers; soft reset returns all to defaults
	always @(posedge MCLK) begin
		if (clr_all) begin
			soft_rst               <= 1'b0;
			att_rst                <= 1'b0;
			EXT_REF_COMMON_MODE    <= 1'b0;
			DCC_ENABLE             <= 1'b0;
			DIFF_CLOCK             <= 1'b0;
			OUTPUT_BIT_CLOCK_PHASE <= 2'h0;
			NOISE_SUPPRESS         <= 1'b0;
			DIGITAL_GAIN           <= 32'h0000_0000;
			TWOS_COMPLEMENT_FORMAT <= 1'b0;
			MSB_FIRST              <= 1'b0;
			SDR_MODE               <= 1'b0;
			LVDS_CLOCK_CURRENT     <= 3'h0;
			LVDS_DATA_CURRENT      <= 3'h0;
		end else if (wr_stb) begin
			case (wr_addr)
			`SCV_ADDR_SOFT_RESET: begin
				// One-cycle pulse; the bit never stays set
				soft_rst <= wr_data[`SCV_BIT_SOFT_RESET];
			end
			`SCV_ADDR_ATT_RESET: begin
				att_rst <= wr_data[`SCV_BIT_ATT_RESET];
			end
			`SCV_ADDR_LVDS_CURRENT: begin
				LVDS_CLOCK_CURRENT <= wr_data[`SCV_CUR_CLK_LO +: 3];
				LVDS_DATA_CURRENT  <= wr_data[`SCV_CUR_DATA_LO +: 3];
			end
			`SCV_ADDR_NOISE: begin
				NOISE_SUPPRESS <= wr_data[`SCV_BIT_NOISE];
			end
			`SCV_ADDR_GAIN_A: begin
				DIGITAL_GAIN[15:0] <= {wr_data[3:0], wr_data[7:4],
					wr_data[11:8], wr_data[15:12]};
			end
			`SCV_ADDR_GAIN_B: begin
				DIGITAL_GAIN[31:16] <= {wr_data[3:0], wr_data[7:4],
					wr_data[11:8], wr_data[15:12]};
			end
			`SCV_ADDR_CLOCKING: begin
				DIFF_CLOCK          <= wr_data[`SCV_BIT_DIFF_CLK];
				DCC_ENABLE          <= wr_data[`SCV_BIT_DCC];
				EXT_REF_COMMON_MODE <= wr_data[`SCV_BIT_EXT_REF];
				OUTPUT_BIT_CLOCK_PHASE <=
					wr_data[`SCV_PHASE_LO +: 2];
			end
			`SCV_ADDR_FORMAT: begin
				TWOS_COMPLEMENT_FORMAT <= wr_data[`SCV_BIT_TWOS];
				MSB_FIRST              <= wr_data[`SCV_BIT_MSB_FIRST];
				SDR_MODE               <= wr_data[`SCV_BIT_SDR];
			end
			default: begin
				soft_rst <= 1'b0;
			end
			endcase
		end else begin
			soft_rst <= 1'b0;
		end
	end

	// Attenuator word registers; held at defaults under attenuator reset
	always @(posedge MCLK) begin
		if (clr_all || att_rst) begin
			att_low  <= `SCV_ATT_LOW_RESET;
			att_mid  <= `SCV_ATT_MID_RESET;
			att_high <= `SCV_ATT_HIGH_RESET;
		end else if (att_hit) begin
			case (wr_addr)
			`SCV_ADDR_ATT_LOW:  att_low  <= wr_data;
			`SCV_ADDR_ATT_MID:  att_mid  <= wr_data;
			default:            att_high <= wr_data[7:0];
			endcase
		end
	end

	// Collect changes over a frame; forward once at its end
	always @(posedge MCLK) begin
		if (clr_all || att_rst) begin
			changed <= 1'b0;
			pending <= 1'b0;
		end else begin
			if (frame_end)
				changed <= 1'b0;
			else if (change_now)
				changed <= 1'b1;
			// A change in the closing cycle still counts; set wins
			if (frame_end && (changed || change_now))
				pending <= 1'b1;
			else if (start)
				pending <= 1'b0;
		end
	end

	// Gated oscillator and shifter for the 40-bit word
	always @(posedge MCLK) begin
		if (clr_all || att_rst) begin
			state                   <= ST_IDLE;
			div_cnt                 <= 8'h00;
			out_cnt                 <= 6'h00;
			out_word                <= 40'h00_0000_0000;
			ATTENUATOR_SERIAL_CLOCK <= 1'b0;
			ATTENUATOR_SERIAL_DATA  <= 1'b0;
			ATTENUATOR_BUSY         <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				ATTENUATOR_SERIAL_CLOCK <= 1'b0;
				ATTENUATOR_SERIAL_DATA  <= 1'b0;
				if (start) begin
					// Whole word snapshot, bit 0 set up before first rise
					out_word               <= att_word;
					ATTENUATOR_SERIAL_DATA <= att_word[0];
					div_cnt                <= 8'h00;
					out_cnt                <= 6'h00;
					state                  <= ST_SHIFT;
					ATTENUATOR_BUSY        <= 1'b1;
				end
			end
			ST_SHIFT: begin
				if (div_cnt == HALF_CYCLES - 8'h01) begin
					div_cnt <= 8'h00;
					if (!ATTENUATOR_SERIAL_CLOCK) begin
						ATTENUATOR_SERIAL_CLOCK <= 1'b1;
					end else begin
						ATTENUATOR_SERIAL_CLOCK <= 1'b0;
						if (out_cnt == `SCV_ATT_LAST_BIT) begin
							// Oscillator stops after bit 39
							state                  <= ST_IDLE;
							ATTENUATOR_SERIAL_DATA <= 1'b0;
							ATTENUATOR_BUSY        <= 1'b0;
						end else begin
							out_word <= {1'b0, out_word[39:1]};
							ATTENUATOR_SERIAL_DATA <= out_word[1];
							out_cnt  <= out_cnt + 6'h01;
						end
					end
				end else begin
					div_cnt <= div_cnt + 8'h01;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// Chip select follows hardware reset and the attenuator reset bit
	always @(posedge MCLK) begin
		if (!RESETN)
			ATTENUATOR_CHIP_SELECT <= 1'b1;
		else
			ATTENUATOR_CHIP_SELECT <= att_rst;
	end

endmodule // scv_serial_config

`default_nettype wire

// ==== scv_checker.sv ====
// Purpose: Port assertions for scv_serial_config
// Assumes: 8-cycle half period, 40-bit word
// Notes:   Bound to every instance
`timescale 1ns/1ns
`default_nettype none
module scv_checker (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic ATTENUATOR_SERIAL_CLOCK,
	input wire logic ATTENUATOR_SERIAL_DATA,
	input wire logic ATTENUATOR_CHIP_SELECT,
	input wire logic ATTENUATOR_BUSY
);
	wire logic sck = ATTENUATOR_SERIAL_CLOCK;
	wire logic sd  = ATTENUATOR_SERIAL_DATA;
	wire logic cs  = ATTENUATOR_CHIP_SELECT;
	wire logic bsy = ATTENUATOR_BUSY;
	int        n_cyc;
	int        n_edge;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	// Length and clock edges of the running transfer
	always @(posedge MCLK) begin
		if (!RESETN || !bsy) begin
			n_cyc <= 0;
			n_edge <= 0;
		end else begin
			n_cyc <= n_cyc + 1;
			n_edge <= n_edge + int'($rose(sck));
		end
	end
	sequence s_high8; sck[*8] ##1 !sck; endsequence
	sequence s_rst3; !RESETN[*3]; endsequence
	property p_idle_clk; !bsy |-> !sck; endproperty
	property p_idle_data; !bsy |-> !sd; endproperty
	property p_half; $rose(sck) |-> s_high8; endproperty
	property p_ones; $rose(bsy) |-> sd ##16 sd; endproperty
	property p_hold; sck |-> $stable(sd); endproperty
	property p_len; $fell(bsy) |-> n_cyc == 640; endproperty
	property p_edges; $fell(bsy) |-> n_edge == 40; endproperty
	property p_cs_rst; disable iff (1'b0) s_rst3 |-> cs; endproperty
	property p_cs_rel; $rose(RESETN) |=> !cs; endproperty
	property p_quiet; cs |-> !$rose(bsy); endproperty
	a_idle_clk: assert property (p_idle_clk)
		else $error("clock active while idle");
	a_idle_data: assert property (p_idle_data)
		else $error("data active while idle");
	a_half: assert property (p_half)
		else $error("clock high phase not 8 cycles");
	a_ones: assert property (p_ones)
		else $error("first two bits not one");
	a_hold: assert property (p_hold)
		else $error("data moved while clock high");
	a_len: assert property (p_len)
		else $error("transfer length wrong");
	a_edges: assert property (p_edges)
		else $error("clock edge count wrong");
	a_cs_rst: assert property (p_cs_rst)
		else $error("select low during reset");
	a_cs_rel: assert property (p_cs_rel)
		else $error("select stuck after reset");
	a_quiet: assert property (p_quiet)
		else $error("transfer while held in reset");
endmodule // scv_checker
bind scv_serial_config scv_checker u_chk (.MCLK, .RESETN,
	.ATTENUATOR_SERIAL_CLOCK, .ATTENUATOR_SERIAL_DATA,
	.ATTENUATOR_CHIP_SELECT, .ATTENUATOR_BUSY);
`default_nettype wire

// ==== scv_host.sv ====
// Purpose: Host controller model for the serial port
// Assumes: 125 ns serial clock, data set while clock low
// Notes:   Clock parks low, data inverted between frames
`timescale 1ns/1ns
`default_nettype none
module scv_host (
	output var logic SEN_N,
	output var logic SCLK,
	output var logic SDATA
);
	// Idle port: deselected, clock parked low
	initial begin
		SEN_N = 1'b1;
		SCLK = 1'b0;
		SDATA = 1'b0;
	end
	// One frame: address byte then whole words, MSB first
	task automatic send(input logic [7:0] a, input logic [15:0] w[$]);
		logic q[$];
		for (int i = 7; i >= 0; i--) q.push_back(a[i]);
		foreach (w[k]) for (int i = 15; i >= 0; i--) q.push_back(w[k][i]);
		// Step off the MCLK edge the caller woke on
		#1 SEN_N = 1'b0;
		foreach (q[k]) begin
			#31 SDATA = q[k];
			#32 SCLK = 1'b1;
			#62 SCLK = 1'b0;
		end
		#63 SEN_N = 1'b1;
		SDATA = ~SDATA;
		#63;
	endtask
endmodule // scv_host
`default_nettype wire

// ==== test_scv_serial_config.sv ====
// Purpose: Self-checking bench for scv_serial_config
// Assumes: Host model at 125 ns serial period
// Notes:   Word captured on attenuator clock rise
`timescale 1ns/1ns
`default_nettype none
module test_scv_serial_config;
	logic             MCLK = 1'b0;
	logic             RESETN = 1'b0;
	wire logic        SEN_N, SCLK, SDATA, sck, sd, cs, busy;
	wire logic        ext, dcc, dif, nse, twos, msb, sdr;
	wire logic [1:0]  ph;
	wire logic [2:0]  ci, di;
	wire logic [31:0] gain;
	wire logic [46:0] cfg = {ext, dcc, dif, ph, nse, twos, msb, sdr,
		ci, di, gain};
	logic [39:0]      cap;
	int               n_bits = 0;
	int               fails = 0;
	int               n_tests = 0;
	always #5 MCLK = ~MCLK;
	scv_host u_host (.SEN_N(SEN_N), .SCLK(SCLK), .SDATA(SDATA));
	scv_serial_config u_dut (.MCLK(MCLK), .RESETN(RESETN),
		.SEN_N(SEN_N), .SCLK(SCLK), .SDATA(SDATA),
		.ATTENUATOR_SERIAL_CLOCK(sck), .ATTENUATOR_SERIAL_DATA(sd),
		.ATTENUATOR_CHIP_SELECT(cs), .ATTENUATOR_BUSY(busy),
		.EXT_REF_COMMON_MODE(ext), .DCC_ENABLE(dcc), .DIFF_CLOCK(dif),
		.NOISE_SUPPRESS(nse), .DIGITAL_GAIN(gain),
		.TWOS_COMPLEMENT_FORMAT(twos), .MSB_FIRST(msb), .SDR_MODE(sdr),
		.OUTPUT_BIT_CLOCK_PHASE(ph), .LVDS_CLOCK_CURRENT(ci),
		.LVDS_DATA_CURRENT(di));
	// Bit 0 arrives first, so shift in from the top
	always @(posedge sck) begin
		cap = {sd, cap[39:1]};
		n_bits++;
	end
	task automatic check(input string nm, input logic [47:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic put(input logic [7:0] a, input logic [15:0] w[$]);
		u_host.send(a, w);
		repeat (4) @(posedge MCLK);
	endtask
	// Write, then wait boundedly for a transfer and judge it
	task automatic att(input logic [7:0] a, input logic [15:0] w[$],
		input logic [39:0] exp, input bit tr);
		int n0;
		n0 = n_bits;
		u_host.send(a, w);
		for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge MCLK);
		for (int i = 0; i < 700 && busy === 1'b1; i++) @(posedge MCLK);
		check("bits", 48'(n_bits - n0), tr ? 48'h28 : 48'h0);
		if (tr) check("word", 48'(cap), 48'(exp));
	endtask
	task automatic t_config();
		check("cfg", 48'(cfg), 48'h0);
		put(8'h42, '{16'h006D});
		put(8'h46, '{16'h001C});
		put(8'h11, '{16'h002B});
		put(8'h14, '{16'h0001});
		put(8'h2A, '{16'h1234, 16'h5678});
		check("cfg", 48'(cfg), 48'h7FDD_8765_4321);
		check("quiet", 48'(n_bits), 48'h0);
		$display("t_config done");
	endtask
	task automatic t_att();
		att(8'h17, '{16'hA5C3}, 40'h00_A5C3_0023, 1);
		att(8'h17, '{16'hA5C3}, 40'h0, 0);
		att(8'h16, '{16'h0FF0, 16'h1234, 16'h00BE}, 40'hBE_1234_0FF3, 1);
		att(8'h18, '{16'h0042}, 40'h42_1234_0FF3, 1);
		$display("t_att done");
	endtask
	task automatic t_soft();
		put(8'h00, '{16'h0001});
		check("cfg", 48'(cfg), 48'h0);
		att(8'h17, '{16'h1234}, 40'h00_1234_0023, 1);
		$display("t_soft done");
	endtask
	task automatic t_att_reset();
		put(8'h03, '{16'h0020});
		check("cs", 48'(cs), 48'h1);
		att(8'h16, '{16'h5555}, 40'h0, 0);
		put(8'h03, '{16'h0000});
		check("cs", 48'(cs), 48'h0);
		att(8'h17, '{16'h1234}, 40'h00_1234_0023, 1);
		$display("t_att_reset done");
	endtask
	// Change while forwarding: this word ends, the new one follows
	task automatic t_queue();
		int n0;
		n0 = n_bits;
		u_host.send(8'h17, '{16'h0F0F});
		u_host.send(8'h18, '{16'h0077});
		check("busy", 48'(busy), 48'h1);
		for (int i = 0; i < 700 && n_bits - n0 < 40; i++) @(posedge MCLK);
		check("word", 48'(cap), 48'h00_0F0F_0023);
		for (int i = 0; i < 1400 && n_bits - n0 < 80; i++) @(posedge MCLK);
		for (int i = 0; i < 700 && busy === 1'b1; i++) @(posedge MCLK);
		check("bits", 48'(n_bits - n0), 48'h50);
		check("word", 48'(cap), 48'h77_0F0F_0023);
		$display("t_queue done");
	endtask
	// Hardware reset in mid-transfer: outputs quiet, select high
	task automatic t_hw_reset();
		put(8'h46, '{16'h001C});
		u_host.send(8'h16, '{16'h00F0});
		@(posedge MCLK);
		check("busy", 48'(busy), 48'h1);
		RESETN <= 1'b0;
		repeat (4) @(posedge MCLK);
		check("rst", 48'({cs, busy, sck, sd}), 48'h8);
		RESETN <= 1'b1;
		repeat (4) @(posedge MCLK);
		check("cs", 48'(cs), 48'h0);
		check("cfg", 48'(cfg), 48'h0);
		att(8'h17, '{16'h0F0F}, 40'h00_0F0F_0023, 1);
		$display("t_hw_reset done");
	endtask
	// Reset, then the scenarios in order
	initial begin
		repeat (4) @(posedge MCLK);
		check("cs", 48'(cs), 48'h1);
		RESETN <= 1'b1;
		repeat (4) @(posedge MCLK);
		t_config();
		t_att();
		t_soft();
		t_att_reset();
		t_queue();
		t_hw_reset();
		wrap_up();
	end
	// Hang guard: about two and a half times the expected run
	initial begin
		#300_000;
		fails++;
		wrap_up();
	end
endmodule // test_scv_serial_config
`default_nettype wire
